/* core/pwm_defs.svh */
// Register offsets, field positions and reset values of the PWM block
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH

// Register byte addresses
`define PWM_ADDR_CTRL 8'h00
`define PWM_ADDR_PRESCALE 8'h04
`define PWM_ADDR_PERIOD 8'h08
`define PWM_ADDR_SYNC_DELAY 8'h0C
`define PWM_ADDR_OUT_CFG 8'h10
`define PWM_ADDR_IRQ_EN 8'h14
`define PWM_ADDR_STATUS 8'h18
`define PWM_ADDR_CAPTURE0 8'h1C
`define PWM_ADDR_CAPTURE1 8'h20
`define PWM_ADDR_CAPTURE2 8'h24
// Edge registers: base + 8*channel, rise at +0, fall at +4
`define PWM_ADDR_EDGE_BASE 2'h1

// Control register fields
`define PWM_CTRL_RUN 0
`define PWM_CTRL_ONCE 1
`define PWM_CTRL_SLAVE 2
`define PWM_CTRL_BURST 3
`define PWM_CTRL_TRAP_EN 4
`define PWM_CTRL_TRAP_CLR 6

// Output configuration fields
`define PWM_OCFG_TRAP_LSB 0
`define PWM_OCFG_BURST_LSB 8

// Interrupt enable fields
`define PWM_IEN_MATCH_LSB 0
`define PWM_IEN_CAP_LSB 16
`define PWM_IEN_OVF 19
`define PWM_IEN_TRAP 20

// Status fields
`define PWM_STAT_RUNNING 16
`define PWM_STAT_TRAPPED 17
`define PWM_STAT_DIRTY 18
`define PWM_STAT_OUT_LSB 24

// Reset values
`define PWM_RST_CTRL 8'h00
`define PWM_RST_COUNT 16'h0000
`define PWM_RST_PERIOD 16'hFFFF

`endif

/* core/pwm_pkg.sv */
// Types shared by the PWM block
package pwm_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0] addr_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } cnt_state_t;
endpackage : pwm_pkg

/* core/six_channel_pwm_with_sync.sv */
// Six-output PWM with prescaler, capture, trap, burst mixing and chain sync
//
// Notes on behaviour
// - Six waveform outputs from one period counter
// - Rise and fall positions programmed per output
// - Optional request per edge match, per-edge enable
// - Continuous repeats; run-once stops after one period
// - 16-bit prescaler feeds 16-bit period counter
// - Trap forces software-chosen levels, optional request
// - Three capture registers latch counter on trigger
// - Requests for match, capture, overflow, trap
// - Burst mode gates waveforms with external carrier
// - Counters and bus logic share one base clock
// - All timing counted in branch clock periods
// - Sync outputs feed next module's sync inputs
// - Master emits one-cycle period-start pulse
// - Shadow-load pulse only when settings were copied
// - Programmable delay before both chain pulses
// - Slave restarts and loads from incoming pulses
//
// Added by the designer: strobed register access and the register addresses.
`include "pwm_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module six_channel_pwm_with_sync #(
  parameter int CH = 6,
  parameter int CW = 16
) (
  // Clock, enable and reset
  input wire logic CLOCK,
  input wire logic CE,
  input wire logic RST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire pwm_pkg::word_t WDATA,
  input wire logic WR,
  input wire logic RD,
  output pwm_pkg::word_t RDATA,
  // Waveform, capture, trap and carrier pins
  output logic [CH-1:0] WAVEFORM_OUTPUT,
  input wire logic [2:0] CAPTURE_TRIGGER_INPUT,
  input wire logic FAULT_HOLD,
  input wire logic CARRIER,
  // Chain to neighbour modules
  input wire logic SYNC_IN,
  input wire logic TRANS_EN_IN,
  output logic SYNC_OUT,
  output logic TRANS_EN_OUT,
  // Interrupt request pulses
  output logic [2*CH-1:0] IRQ_MATCH,
  output logic [2:0] IRQ_CAPTURE,
  output logic IRQ_OVERFLOW,
  output logic IRQ_TRAP
);
  import pwm_pkg::*;

  // Field widths in the register map cap both parameters
  if (CH < 1 || CH > 8) begin : g_bad_ch
    $error("CH must lie between 1 and 8");
  end
  if (CW < 2 || CW > 16) begin : g_bad_cw
    $error("CW must lie between 2 and 16");
  end

  // Widen a counter-sized value to a bus word
  function automatic word_t widen(input logic [CW-1:0] v);
    widen = {{(32-CW){1'b0}}, v};
  endfunction : widen

  // Register state
  logic [7:0] ctrl_q;
  logic [CW-1:0] pre_stage_q, per_stage_q, pre_sh_q, per_sh_q, delay_q;
  logic [CW-1:0] rise_stage_q [CH];
  logic [CW-1:0] fall_stage_q [CH];
  logic [CW-1:0] rise_sh_q [CH];
  logic [CW-1:0] fall_sh_q [CH];
  logic [CH-1:0] trap_lvl_q, burst_q;
  logic [20:0] ien_q;
  logic [CW-1:0] cap_q [3];
  logic dirty_q, dirty_d;
  logic trapped_q, trapped_d;
  logic [2:0] cap_prev_q;
  // Counter state
  cnt_state_t state_q, state_d;
  logic [CW-1:0] pre_q, cnt_q;
  logic [CH-1:0] wave_q;
  // Chain delay state
  logic [CW-1:0] dly_cnt_q;
  logic dly_busy_q, dly_xfer_q;

  // Address decode
  logic wr_ctrl, wr_pre, wr_per, wr_dly, wr_ocfg, wr_ien, edge_hit, wr_edge;
  logic [2:0] edge_ch;
  assign wr_ctrl = WR && ADDR == `PWM_ADDR_CTRL;
  assign wr_pre = WR && ADDR == `PWM_ADDR_PRESCALE;
  assign wr_per = WR && ADDR == `PWM_ADDR_PERIOD;
  assign wr_dly = WR && ADDR == `PWM_ADDR_SYNC_DELAY;
  assign wr_ocfg = WR && ADDR == `PWM_ADDR_OUT_CFG;
  assign wr_ien = WR && ADDR == `PWM_ADDR_IRQ_EN;
  assign edge_ch = ADDR[5:3];
  assign edge_hit = ADDR[7:6] == `PWM_ADDR_EDGE_BASE && ADDR[1:0] == 2'h0 && 32'(edge_ch) < CH;
  assign wr_edge = WR && edge_hit;

  // Control decode
  logic running, slave, once, pre_wrap, per_end, start, wrap, restart, xfer;
  assign running = state_q == ST_RUN;
  assign slave = ctrl_q[`PWM_CTRL_SLAVE];
  assign once = ctrl_q[`PWM_CTRL_ONCE];
  // Master starts on a write setting the run bit while idle
  assign start = slave ? SYNC_IN : (!running && wr_ctrl && WDATA[`PWM_CTRL_RUN]);
  assign pre_wrap = running && pre_q == pre_sh_q;
  assign per_end = pre_wrap && cnt_q == per_sh_q;
  assign wrap = per_end && !once;
  assign restart = start || wrap;
  // Slave copies only when told to by the master
  assign xfer = restart && (slave ? TRANS_EN_IN : dirty_q);

  // Counter state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wr_ctrl && !WDATA[`PWM_CTRL_RUN]) begin
          state_d = ST_IDLE;
        end else if (per_end && once && !start) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Staging marker: a fresh write wins over the copy that clears it
  // Only staged registers mark dirty; the sync delay applies at once
  assign dirty_d = wr_pre || wr_per || wr_edge || (dirty_q && !xfer);

  // Trap latch: a held fault wins over the software clear
  // Levels apply one cycle after the latch sets, so outputs stay registered
  logic trap_evt;
  assign trap_evt = FAULT_HOLD && ctrl_q[`PWM_CTRL_TRAP_EN];
  assign trapped_d = trap_evt || (trapped_q && !(wr_ctrl && WDATA[`PWM_CTRL_TRAP_CLR]));

  // Edge matches, sampled on the first clock of each counter value
  // Matching only on the first tick keeps each request one cycle long under prescale
  logic first_tick;
  logic [CH-1:0] rise_hit, fall_hit;
  assign first_tick = running && pre_q == '0;
  for (genvar i = 0; i < CH; i++) begin : g_match
    assign rise_hit[i] = first_tick && cnt_q == rise_sh_q[i];
    assign fall_hit[i] = first_tick && cnt_q == fall_sh_q[i];
  end

  // Capture edges; trigger pins are synchronous to the clock
  // The previous sample resets low, the idle pin level, so reset makes no false edge
  logic [2:0] cap_edge;
  assign cap_edge = CAPTURE_TRIGGER_INPUT & ~cap_prev_q;

  // Output mix: trap overrides burst, burst gates with the carrier
  // Trade-off: the output register adds a cycle but keeps the pins glitch-free
  logic [CH-1:0] burst_mix, out_d;
  assign burst_mix = ctrl_q[`PWM_CTRL_BURST] ? (wave_q & ~(burst_q & {CH{~CARRIER}})) : wave_q;
  assign out_d = trapped_q ? trap_lvl_q : burst_mix;

  // Read mux
  // Data stand only in the cycle after the strobe; an idle bus reads as zero
  word_t rd_d, status;
  assign status = {8'(wave_q), 5'h00, dirty_q, trapped_q, running, 16'(cnt_q)};
  always_comb begin
    rd_d = '0;
    if (edge_hit) begin
      rd_d = widen(ADDR[2] ? fall_stage_q[edge_ch] : rise_stage_q[edge_ch]);
    end else begin
      case (ADDR)
        `PWM_ADDR_CTRL: rd_d = {24'h000000, ctrl_q & 8'h0F | {3'h0, ctrl_q[4], 4'h0}};
        `PWM_ADDR_PRESCALE: rd_d = widen(pre_stage_q);
        `PWM_ADDR_PERIOD: rd_d = widen(per_stage_q);
        `PWM_ADDR_SYNC_DELAY: rd_d = widen(delay_q);
        `PWM_ADDR_OUT_CFG: rd_d = {16'h0000, 8'(burst_q), 8'(trap_lvl_q)};
        `PWM_ADDR_IRQ_EN: rd_d = {11'h000, ien_q};
        `PWM_ADDR_STATUS: rd_d = status;
        `PWM_ADDR_CAPTURE0: rd_d = widen(cap_q[0]);
        `PWM_ADDR_CAPTURE1: rd_d = widen(cap_q[1]);
        `PWM_ADDR_CAPTURE2: rd_d = widen(cap_q[2]);
        default: rd_d = '0; // Unmapped reads return zero
      endcase
    end
  end

  // Software-visible registers; the trap clear bit is not stored
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_q <= `PWM_RST_CTRL;
      pre_stage_q <= '0;
      per_stage_q <= CW'(`PWM_RST_PERIOD);
      delay_q <= '0;
      trap_lvl_q <= '0;
      burst_q <= '0;
      ien_q <= '0;
      RDATA <= '0;
    end else if (CE) begin
      if (wr_ctrl) ctrl_q <= WDATA[7:0] & 8'h1F;
      if (wr_pre) pre_stage_q <= WDATA[CW-1:0];
      if (wr_per) per_stage_q <= WDATA[CW-1:0];
      if (wr_dly) delay_q <= WDATA[CW-1:0];
      if (wr_ocfg) trap_lvl_q <= WDATA[`PWM_OCFG_TRAP_LSB +: CH];
      if (wr_ocfg) burst_q <= WDATA[`PWM_OCFG_BURST_LSB +: CH];
      if (wr_ien) ien_q <= WDATA[20:0];
      RDATA <= RD ? rd_d : '0;
    end
  end

  // Edge staging and shadow registers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < CH; i++) begin
        rise_stage_q[i] <= '0;
        fall_stage_q[i] <= '0;
        rise_sh_q[i] <= '0;
        fall_sh_q[i] <= '0;
      end
    end else if (CE) begin
      for (int i = 0; i < CH; i++) begin
        if (wr_edge && 32'(edge_ch) == i && !ADDR[2]) rise_stage_q[i] <= WDATA[CW-1:0];
        if (wr_edge && 32'(edge_ch) == i && ADDR[2]) fall_stage_q[i] <= WDATA[CW-1:0];
        if (xfer) rise_sh_q[i] <= rise_stage_q[i];
        if (xfer) fall_sh_q[i] <= fall_stage_q[i];
      end
    end
  end

  // Prescale and period shadows, staging marker, trap latch
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pre_sh_q <= '0;
      per_sh_q <= CW'(`PWM_RST_PERIOD);
      dirty_q <= 1'b0;
      trapped_q <= 1'b0;
    end else if (CE) begin
      if (xfer) pre_sh_q <= pre_stage_q;
      if (xfer) per_sh_q <= per_stage_q;
      dirty_q <= dirty_d;
      trapped_q <= trapped_d;
    end
  end

  // Prescale and period counters, one branch-clock step each cycle
  // A restart outranks the prescale wrap, so a slave realigns at once
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
      pre_q <= CW'(`PWM_RST_COUNT);
      cnt_q <= CW'(`PWM_RST_COUNT);
    end else if (CE) begin
      state_q <= state_d;
      if (restart) begin
        pre_q <= '0;
        cnt_q <= '0;
      end else if (pre_wrap) begin
        pre_q <= '0;
        cnt_q <= per_end ? cnt_q : cnt_q + CW'(1);
      end else if (running) begin
        pre_q <= pre_q + CW'(1);
      end
    end
  end

  // Waveforms: fall takes priority when both positions coincide
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      wave_q <= '0;
      WAVEFORM_OUTPUT <= '0;
    end else if (CE) begin
      wave_q <= (wave_q | rise_hit) & ~fall_hit;
      WAVEFORM_OUTPUT <= out_d;
    end
  end

  // Capture registers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cap_prev_q <= '0;
      for (int i = 0; i < 3; i++) cap_q[i] <= '0;
    end else if (CE) begin
      cap_prev_q <= CAPTURE_TRIGGER_INPUT;
      for (int i = 0; i < 3; i++) begin
        if (cap_edge[i]) cap_q[i] <= cnt_q;
      end
    end
  end

  // Chain delay: a new restart retriggers and replaces a pending one
  // Limitation: restarts spaced closer than the delay lose the pending pulse
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      dly_cnt_q <= '0;
      dly_busy_q <= 1'b0;
      dly_xfer_q <= 1'b0;
      SYNC_OUT <= 1'b0;
      TRANS_EN_OUT <= 1'b0;
    end else if (CE) begin
      SYNC_OUT <= 1'b0;
      TRANS_EN_OUT <= 1'b0;
      if (restart) begin
        dly_cnt_q <= delay_q;
        dly_busy_q <= 1'b1;
        dly_xfer_q <= xfer;
      end else if (dly_busy_q && dly_cnt_q == '0) begin
        dly_busy_q <= 1'b0;
        SYNC_OUT <= 1'b1;
        TRANS_EN_OUT <= dly_xfer_q;
      end else if (dly_busy_q) begin
        dly_cnt_q <= dly_cnt_q - CW'(1);
      end
    end
  end

  // Interrupt request pulses, each gated by its enable
  // Raw pulses: software that needs sticky status must latch them outside
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      IRQ_MATCH <= '0;
      IRQ_CAPTURE <= '0;
      IRQ_OVERFLOW <= 1'b0;
      IRQ_TRAP <= 1'b0;
    end else if (CE) begin
      IRQ_MATCH <= {fall_hit, rise_hit} & ien_q[`PWM_IEN_MATCH_LSB +: 2*CH];
      IRQ_CAPTURE <= cap_edge & ien_q[`PWM_IEN_CAP_LSB +: 3];
      IRQ_OVERFLOW <= per_end && ien_q[`PWM_IEN_OVF];
      IRQ_TRAP <= trap_evt && !trapped_q && ien_q[`PWM_IEN_TRAP];
    end
  end

endmodule : six_channel_pwm_with_sync

`default_nettype wire

/* verif/pwm_asserts.sv */
// Port-level checker for the six-output PWM
`timescale 1ns/10ps
`default_nettype none
module pwm_asserts #(
  parameter int CH = 6,
  parameter int CW = 16
) (
  // Clock, enable and reset
  input wire logic CLOCK,
  input wire logic CE,
  input wire logic RST,
  // Watched ports
  input wire logic RD,
  input wire pwm_pkg::word_t RDATA,
  input wire logic [CH-1:0] WAVEFORM_OUTPUT,
  input wire logic [2:0] CAPTURE_TRIGGER_INPUT,
  input wire logic FAULT_HOLD,
  input wire logic SYNC_OUT,
  input wire logic TRANS_EN_OUT,
  input wire logic [2*CH-1:0] IRQ_MATCH,
  input wire logic [2:0] IRQ_CAPTURE,
  input wire logic IRQ_TRAP
);
  import pwm_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Read data only in the cycle after a strobe
  chk_rdata_idle: assert property (CE && !RD |=> RDATA == 32'h0) else $error("rdata not zero");
  chk_freeze_hold: assert property (!CE |=> $stable(RDATA) && $stable(WAVEFORM_OUTPUT))
    else $error("state moved while disabled");
  // Chain pulses are single cycles and paired; a frozen cycle holds them
  chk_sync_pulse: assert property (CE && SYNC_OUT |=> !SYNC_OUT)
    else $error("sync too long");
  chk_trans_pair: assert property (TRANS_EN_OUT |-> SYNC_OUT) else $error("load without sync");
  // Trap request needs a recent fault and is a pulse
  chk_trap_cause: assert property (IRQ_TRAP |-> $past(FAULT_HOLD) || $past(FAULT_HOLD, 2))
    else $error("trap request without fault");
  chk_trap_pulse: assert property (CE && IRQ_TRAP |=> !IRQ_TRAP)
    else $error("trap request too long");
  // A capture request only follows its own trigger
  chk_cap_cause: assert property ((IRQ_CAPTURE & ~($past(CAPTURE_TRIGGER_INPUT)
    | $past(CAPTURE_TRIGGER_INPUT, 2))) == 3'h0) else $error("capture without trigger");
  chk_match_pulse: assert property (CE && IRQ_MATCH[0] |=> !IRQ_MATCH[0])
    else $error("match too long");
  // Main scenarios
  cov_sync_load: cover property (SYNC_OUT && TRANS_EN_OUT);
  cov_trap: cover property (IRQ_TRAP);
  cov_capture: cover property (IRQ_CAPTURE[1]);
  cov_freeze: cover property (!CE);
endmodule : pwm_asserts
bind six_channel_pwm_with_sync pwm_asserts #(.CH(CH), .CW(CW)) u_chk (.CLOCK(CLOCK), .CE(CE),
  .RST(RST), .RD(RD), .RDATA(RDATA), .WAVEFORM_OUTPUT(WAVEFORM_OUTPUT),
  .CAPTURE_TRIGGER_INPUT(CAPTURE_TRIGGER_INPUT), .FAULT_HOLD(FAULT_HOLD), .SYNC_OUT(SYNC_OUT),
  .TRANS_EN_OUT(TRANS_EN_OUT), .IRQ_MATCH(IRQ_MATCH), .IRQ_CAPTURE(IRQ_CAPTURE),
  .IRQ_TRAP(IRQ_TRAP));
`default_nettype wire

/* verif/peer_master.sv */
// Upstream peer model: chain pulses and burst carrier
`timescale 1ns/10ps
`default_nettype none
module peer_master (
  // Clock and commands
  input wire logic clk,
  input wire logic go,
  input wire logic load,
  input wire logic carrier_on,
  // Chain and carrier outputs
  output logic sync_in,
  output logic trans_en_in,
  output logic carrier
);
  logic [1:0] div_q = 2'h0;
  // Shadow-load only ever rides beside a period-start pulse
  always_ff @(posedge clk) begin
    sync_in <= go;
    trans_en_in <= go && load;
    div_q <= div_q + 2'h1;
  end
  // Slow square carrier; held low while carrier_on is low
  assign carrier = carrier_on && div_q[1];
endmodule : peer_master
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the six-output PWM
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pwm_pkg::*;
  logic clk = 1'b0, ce = 1'b1, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, fault = 1'b0, pend = 1'b0;
  logic go = 1'b0, load = 1'b0, car_on = 1'b0;
  logic [7:0] addr = 8'h00;
  word_t wdata = 32'h0, rdata;
  logic [5:0] wave, lv;
  logic [2:0] cap = 3'h0, irq_c;
  logic [11:0] irq_m;
  logic sync_i, trans_i, carrier, sync_o, trans_o, irq_o, irq_t;
  logic [63:0] q[$];
  int n_errors = 0, tests_run = 0, n, m, p, d, i;
  always #10 clk = ~clk;
  six_channel_pwm_with_sync DUT (.CLOCK(clk), .CE(ce), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .RDATA(rdata), .WAVEFORM_OUTPUT(wave), .CAPTURE_TRIGGER_INPUT(cap),
    .FAULT_HOLD(fault), .CARRIER(carrier), .SYNC_IN(sync_i), .TRANS_EN_IN(trans_i),
    .SYNC_OUT(sync_o), .TRANS_EN_OUT(trans_o), .IRQ_MATCH(irq_m), .IRQ_CAPTURE(irq_c),
    .IRQ_OVERFLOW(irq_o), .IRQ_TRAP(irq_t));
  peer_master u_peer (.clk(clk), .go(go), .load(load), .carrier_on(car_on), .sync_in(sync_i),
    .trans_en_in(trans_i), .carrier(carrier));
  task automatic report_and_stop;
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input word_t e, input word_t s);
    tests_run++;
    if (e !== s) begin
      $display("BAD %s exp %h got %h", nm, e, s);
      n_errors++;
    end
  endtask : chk
  // Bus master: one-cycle strobes launched after an edge
  task automatic wr(input logic [7:0] a, input word_t v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input word_t e, input word_t mk);
    q.push_back({mk, e & mk});
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
  endtask : rd
  // Read data is looked at once, mid-cycle, in its only valid cycle
  always @(posedge clk) pend <= rd_s;
  always @(negedge clk) begin
    logic [63:0] t;
    if (pend) begin
      t = q.pop_front();
      chk("rdata", t[31:0], rdata & t[63:32]);
    end
  end
  function automatic logic ev(input int k);
    case (k)
      0: return sync_o;
      1: return irq_o;
      2: return irq_t;
      3: return irq_c[1];
      4: return wave[0];
      6: return irq_m[6];
      default: return !wave[0];
    endcase
  endfunction : ev
  // Bounded wait on an event; a hang ends the run as a failure
  task automatic wait_ev(input int k, output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (ev(k) !== 1'b1 && c < 2000);
    if (c >= 2000) begin
      n_errors++;
      report_and_stop();
    end
  endtask : wait_ev
  initial begin
    n = $urandom(30869);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h0, '1);
    rd(8'h08, 32'h0000FFFF, '1);
    rd(8'hFC, 32'h0, '1);
    rd(8'h18, 32'h0, '1);
    // Continuous run with staged settings
    p = $urandom_range(3, 1);
    wr(8'h04, p);
    wr(8'h08, 32'h3);
    wr(8'h40, 32'h1);
    wr(8'h44, 32'h3);
    wr(8'h14, 32'h001FFFFF);
    rd(8'h18, 32'h00040000, 32'h00050000);
    wr(8'h00, 32'h1);
    wait_ev(0, n);
    chk("load_first", 32'h1, 32'(trans_o));
    rd(8'h18, 32'h00010000, 32'h00050000);
    wait_ev(0, n);
    wait_ev(0, n);
    chk("period", 4 * (p + 1), n);
    chk("load_idle", 32'h0, 32'(trans_o));
    wait_ev(5, n);
    wait_ev(4, n);
    wait_ev(5, n);
    chk("duty", 2 * (p + 1), n);
    // Fall request leads the registered output by one cycle
    wait_ev(6, n);
    wait_ev(5, n);
    chk("fall_irq", 32'h1, n);
    // Delay from restart to chain pulses
    wait_ev(1, n);
    wait_ev(0, n);
    d = $urandom_range(2, 1);
    wr(8'h0C, d);
    wait_ev(0, m);
    wait_ev(1, m);
    wait_ev(0, m);
    chk("delay", n + d, m);
    // Run-once stops after one period
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h3);
    repeat (4 * (p + 1) + d + 8) @(posedge clk);
    rd(8'h18, 32'h0, 32'h00010000);
    // Trap forces chosen levels until cleared
    lv = 6'($urandom);
    wr(8'h10, lv);
    wr(8'h00, 32'h11);
    fault <= 1'b1;
    wait_ev(2, n);
    repeat (2) @(negedge clk);
    chk("trap_out", lv, wave);
    rd(8'h18, 32'h00020000, 32'h00020000);
    fault <= 1'b0;
    wr(8'h00, 32'h51);
    rd(8'h18, 32'h0, 32'h00020000);
    // Capture trigger
    cap <= 3'h2;
    @(posedge clk);
    cap <= 3'h0;
    wait_ev(3, n);
    rd(8'h20, 32'h0, 32'hFFFFFFFC);
    rd(8'h24, 32'h0, '1);
    // Slave loads shadows only with the incoming load pulse
    wr(8'h00, 32'h5);
    wr(8'h08, 32'h5);
    for (i = 0; i < 2; i++) begin
      go <= 1'b1;
      load <= i[0];
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
      rd(8'h18, i ? 32'h0 : 32'h00040000, 32'h00040000);
    end
    // Burst mixing: paused carrier keeps the masked output low
    wr(8'h10, 32'h100);
    wr(8'h00, 32'h9);
    repeat (4) @(posedge clk);
    for (i = 0; i < 30; i++) begin
      @(negedge clk);
      chk("burst", 32'h0, 32'(wave[0]));
    end
    @(posedge clk);
    car_on <= 1'b1;
    wait_ev(4, n);
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
